// ===== hdl/acc_pkg.sv
// Constants, register map and state codes of the analog command conditioner
package acc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SAMPLE_US = 50;
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int DATA_W = 16;
    localparam int HIST_DEPTH = 16;
    localparam int HIST_AW = 4;
    localparam int SUM_W = 20;
    localparam int FILL_W = 5;
    localparam logic [2:0] FILT_MAX = 3'h4;
    localparam logic [4:0] FILL_FULL = 5'h10;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_INFUNC_LO = 8'h04;
    localparam logic [7:0] OFS_INFUNC_HI = 8'h08;
    localparam logic [7:0] OFS_SPDLIM = 8'h0c;
    localparam logic [7:0] OFS_FWDLIM = 8'h10;
    localparam logic [7:0] OFS_REVLIM = 8'h14;
    localparam logic [7:0] OFS_OFFSET = 8'h18;
    localparam logic [7:0] OFS_DEADBAND = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_FILT = 8'h24;
    localparam logic [7:0] OFS_CURRENT = 8'h28;

    // ****************************************
    // Fields and codes
    // ****************************************
    localparam int CFG_FILT_LSB = 0;
    localparam int CFG_TSEL_LSB = 8;
    localparam int CFG_MODE_LSB = 16;
    localparam int CFG_SW_LSB = 24;
    localparam int TSEL_INVERT_BIT = 7;
    localparam logic [6:0] TSEL_LIMITED = 7'h03;
    localparam logic [7:0] MODE_SPEED = 8'h02;
    localparam int SW_KEEP_BIT = 2;
    localparam logic [7:0] FUNC_FORCE_ZERO = 8'h0e;
    localparam logic [7:0] FUNC_SERVO_ON = 8'h01;
    localparam int ST_EXCITE_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_HIT_BIT = 2;
    localparam int ST_OVALID_BIT = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] INFUNC_LO_RST = 32'h0000_0001;
    localparam logic [31:0] INFUNC_HI_RST = 32'h0000_0000;
    localparam logic [15:0] LIM_RST = 16'h7fff;

    typedef enum logic [3:0] {
        ACC_IDLE = 4'b0001,
        ACC_UPD = 4'b0010,
        ACC_AVG = 4'b0100,
        ACC_PUSH = 4'b1000
    } acc_state_t;

endpackage

// ===== hdl/acc_hist_if.sv
// Interface between the filter core and its sample history memory
`timescale 1ns/100ps
`default_nettype none
interface acc_hist_if;
    logic wr_en;
    logic [acc_pkg::HIST_AW-1:0] wr_addr;
    logic [acc_pkg::DATA_W-1:0] wr_data;
    logic rd_en;
    logic [acc_pkg::HIST_AW-1:0] rd_addr;
    logic [acc_pkg::DATA_W-1:0] rd_data;
    modport core (output wr_en, output wr_addr, output wr_data, output rd_en,
        output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_en,
        input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== hdl/acc_hist_mem.sv
// Sample history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module acc_hist_mem
(
    // Clock
    input wire logic pclk,
    // Port
    acc_hist_if.mem hist
);
    logic [acc_pkg::DATA_W-1:0] store [acc_pkg::HIST_DEPTH];

    // No reset on the array; the core tracks how many entries are valid
    always_ff @(posedge pclk)
    begin
        if (hist.wr_en)
        begin
            store[hist.wr_addr] <= hist.wr_data;
        end
        if (hist.rd_en)
        begin
            hist.rd_data <= store[hist.rd_addr];
        end
    end
endmodule
`default_nettype wire

// ===== hdl/acc_top.sv
// Analog command conditioner: averaging, override, limiting, APB registers
`timescale 1ns/100ps
`default_nettype none
module acc_top
#(
    parameter int SAMPLE_CYCLES = acc_pkg::SAMPLE_CYCLES
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive side inputs
    input wire logic [15:0] adc_sample,
    input wire logic [7:0] gen_inputs,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] speed_loop_current,
    // Current command stream
    output logic cur_valid,
    input wire logic cur_ready,
    output logic [15:0] cur_data,
    // Drive controls
    output logic [15:0] speed_cmd,
    output logic motor_excite
);
    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [14:0] acc_abs(input logic signed [15:0] v);
        logic [15:0] m;
        m = v[15] ? 16'(-v) : 16'(v);
        return m[15] ? 15'h7fff : m[14:0];
    endfunction

    function automatic logic signed [15:0] acc_clamp(input logic signed [15:0] v,
        input logic [14:0] hi, input logic [14:0] lo);
        logic signed [15:0] ph;
        logic signed [15:0] nl;
        ph = $signed({1'b0, hi});
        nl = -$signed({1'b0, lo});
        if (v > ph)
            return ph;
        else if (v < nl)
            return nl;
        return v;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] cfg;
    logic [31:0] infunc_lo;
    logic [31:0] infunc_hi;
    logic [15:0] spd_lim;
    logic [15:0] fwd_lim;
    logic [15:0] rev_lim;
    logic [15:0] offset;
    logic [15:0] deadband;
    logic servo_q;

    wire [7:0] reg_addr = paddr;
    wire wr_stb = psel && penable && pwrite;
    wire setup = psel && !penable;
    wire [63:0] func_all = {infunc_hi, infunc_lo};
    wire [2:0] fset_raw = cfg[acc_pkg::CFG_FILT_LSB +: 3];
    wire [7:0] tsel = cfg[acc_pkg::CFG_TSEL_LSB +: 8];
    wire [7:0] ctl_mode = cfg[acc_pkg::CFG_MODE_LSB +: 8];
    wire [7:0] ctl_sw = cfg[acc_pkg::CFG_SW_LSB +: 8];
    // Settings above 4 act as the longest window
    wire [2:0] fset = (fset_raw > acc_pkg::FILT_MAX) ? acc_pkg::FILT_MAX : fset_raw;

    logic [7:0] zero_hits;
    logic [7:0] servo_hits;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            zero_hits[i] = gen_inputs[i] && (func_all[8*i +: 8] == acc_pkg::FUNC_FORCE_ZERO);
            servo_hits[i] = gen_inputs[i] && (func_all[8*i +: 8] == acc_pkg::FUNC_SERVO_ON);
        end
    end
    wire forced_zero = |zero_hits;
    wire servo_on = |servo_hits;
    wire servo_rise = servo_on && !servo_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= acc_pkg::CFG_RST;
            infunc_lo <= acc_pkg::INFUNC_LO_RST;
            infunc_hi <= acc_pkg::INFUNC_HI_RST;
            fwd_lim <= acc_pkg::LIM_RST;
            rev_lim <= acc_pkg::LIM_RST;
            offset <= 16'h0000;
            deadband <= 16'h0000;
        end
        else if (wr_stb)
        begin
            if (reg_addr == acc_pkg::OFS_CFG) cfg <= pwdata;
            if (reg_addr == acc_pkg::OFS_INFUNC_LO) infunc_lo <= pwdata;
            if (reg_addr == acc_pkg::OFS_INFUNC_HI) infunc_hi <= pwdata;
            if (reg_addr == acc_pkg::OFS_FWDLIM) fwd_lim <= pwdata[15:0];
            if (reg_addr == acc_pkg::OFS_REVLIM) rev_lim <= pwdata[15:0];
            if (reg_addr == acc_pkg::OFS_OFFSET) offset <= pwdata[15:0];
            if (reg_addr == acc_pkg::OFS_DEADBAND) deadband <= pwdata[15:0];
        end
    end

    // Servo-on clear outranks a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spd_lim <= 16'h0000;
            servo_q <= 1'b0;
        end
        else
        begin
            servo_q <= servo_on;
            if (servo_rise && !ctl_sw[acc_pkg::SW_KEEP_BIT])
                spd_lim <= 16'h0000;
            else if (wr_stb && reg_addr == acc_pkg::OFS_SPDLIM)
                spd_lim <= pwdata[15:0];
        end
    end

    // ****************************************
    // Sample tick and filter pipeline
    // ****************************************
    logic [12:0] tick_cnt;
    wire tick = (tick_cnt == 13'(SAMPLE_CYCLES - 1));
    acc_pkg::acc_state_t state;
    acc_pkg::acc_state_t next_state;
    logic signed [15:0] samp;
    logic signed [acc_pkg::SUM_W-1:0] sum;
    logic signed [15:0] filt;
    logic [acc_pkg::HIST_AW-1:0] wptr;
    logic [acc_pkg::FILL_W-1:0] fill;
    logic [2:0] fset_used;

    acc_hist_if hist ();
    acc_hist_mem u_mem (.pclk(pclk), .hist(hist));

    wire [acc_pkg::FILL_W-1:0] win = acc_pkg::FILL_W'(1) << fset;
    wire flush = (fset != fset_used);
    wire signed [15:0] old_val = (fill >= win) ? $signed(hist.rd_data) : 16'sh0000;
    wire signed [acc_pkg::SUM_W-1:0] next_sum = flush ? acc_pkg::SUM_W'(samp)
        : sum + acc_pkg::SUM_W'(samp) - acc_pkg::SUM_W'(old_val);
    wire signed [acc_pkg::SUM_W-1:0] sum_sh = sum >>> fset_used;

    assign hist.rd_en = (state == acc_pkg::ACC_IDLE) && tick;
    assign hist.rd_addr = wptr - acc_pkg::HIST_AW'(win);
    assign hist.wr_en = (state == acc_pkg::ACC_UPD);
    assign hist.wr_addr = wptr;
    assign hist.wr_data = samp;

    always_comb
    begin
        next_state = state;
        unique case (state)
            acc_pkg::ACC_IDLE: if (tick) next_state = acc_pkg::ACC_UPD;
            acc_pkg::ACC_UPD: next_state = acc_pkg::ACC_AVG;
            acc_pkg::ACC_AVG: next_state = acc_pkg::ACC_PUSH;
            acc_pkg::ACC_PUSH: next_state = acc_pkg::ACC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= 13'h0000;
            state <= acc_pkg::ACC_IDLE;
            samp <= 16'sh0000;
            sum <= '0;
            filt <= 16'sh0000;
            wptr <= '0;
            fill <= '0;
            fset_used <= 3'h0;
        end
        else
        begin
            tick_cnt <= tick ? 13'h0000 : tick_cnt + 13'h0001;
            state <= next_state;
            if (hist.rd_en)
                samp <= tsel[acc_pkg::TSEL_INVERT_BIT] ? -$signed(adc_sample)
                    : $signed(adc_sample);
            if (state == acc_pkg::ACC_UPD)
            begin
                sum <= next_sum;
                wptr <= wptr + acc_pkg::HIST_AW'(1);
                fset_used <= fset;
                if (flush)
                    fill <= acc_pkg::FILL_W'(1);
                else if (fill != acc_pkg::FILL_FULL)
                    fill <= fill + acc_pkg::FILL_W'(1);
            end
            if (state == acc_pkg::ACC_AVG)
                filt <= sum_sh[15:0];
        end
    end

    // ****************************************
    // Command shaping and current limits
    // ****************************************
    wire signed [15:0] rel = filt - $signed(offset);
    wire in_band = acc_abs(rel) <= deadband[14:0];
    // Override sits after the filter so it acts without waiting out the window
    wire signed [15:0] cmd_now = (forced_zero || in_band) ? 16'sh0000 : rel;
    wire lim_mode = (tsel[6:0] == acc_pkg::TSEL_LIMITED)
        && (ctl_mode == acc_pkg::MODE_SPEED);
    wire [14:0] cmd_mag = acc_abs(cmd_now);
    wire spd_hit = lim_mode && (acc_abs($signed(motor_speed)) >= spd_lim[14:0]);
    wire signed [15:0] loop_cur = acc_clamp($signed(speed_loop_current), cmd_mag,
        cmd_mag);
    wire signed [15:0] base_cur = spd_hit ? loop_cur : cmd_now;
    wire signed [15:0] lim_cur = acc_clamp(base_cur, fwd_lim[14:0], rev_lim[14:0]);
    wire signed [15:0] cur_now = servo_on ? lim_cur : 16'sh0000;
    wire signed [15:0] spd_mag = $signed({1'b0, spd_lim[14:0]});
    wire signed [15:0] next_speed_cmd = !lim_mode ? 16'sh0000
        : (cmd_now < 0) ? -spd_mag : spd_mag;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            speed_cmd <= 16'h0000;
            motor_excite <= 1'b0;
        end
        else
        begin
            speed_cmd <= next_speed_cmd;
            motor_excite <= servo_on;
        end
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    // A stalled receiver holds the word in pend; later words are skipped until pend empties
    logic pend;
    logic [15:0] pend_word;
    logic [15:0] buf0;
    logic [15:0] buf1;
    logic [1:0] cnt;
    wire buf_in_ready = (cnt != 2'h2);
    wire push = pend && buf_in_ready;
    wire pop = cur_valid && cur_ready;
    assign cur_valid = (cnt != 2'h0);
    assign cur_data = buf0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend <= 1'b0;
            pend_word <= 16'h0000;
            buf0 <= 16'h0000;
            buf1 <= 16'h0000;
            cnt <= 2'h0;
        end
        else
        begin
            if (state == acc_pkg::ACC_PUSH && !pend)
            begin
                pend <= 1'b1;
                pend_word <= cur_now;
            end
            else if (push)
                pend <= 1'b0;
            if (push && !pop)
            begin
                if (cnt == 2'h0) buf0 <= pend_word;
                else buf1 <= pend_word;
                cnt <= cnt + 2'h1;
            end
            else if (pop && !push)
            begin
                buf0 <= buf1;
                cnt <= cnt - 2'h1;
            end
            else if (pop && push)
            begin
                buf0 <= (cnt == 2'h1) ? pend_word : buf1;
                buf1 <= pend_word;
            end
        end
    end

    // ****************************************
    // APB read path
    // ****************************************
    wire [31:0] status = {28'h0, cur_valid, spd_hit, forced_zero, servo_on};
    wire mapped = (reg_addr <= acc_pkg::OFS_CURRENT) && (reg_addr[1:0] == 2'b00);
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            acc_pkg::OFS_CFG: rd_mux = cfg;
            acc_pkg::OFS_INFUNC_LO: rd_mux = infunc_lo;
            acc_pkg::OFS_INFUNC_HI: rd_mux = infunc_hi;
            acc_pkg::OFS_SPDLIM: rd_mux = {16'h0, spd_lim};
            acc_pkg::OFS_FWDLIM: rd_mux = {16'h0, fwd_lim};
            acc_pkg::OFS_REVLIM: rd_mux = {16'h0, rev_lim};
            acc_pkg::OFS_OFFSET: rd_mux = {16'h0, offset};
            acc_pkg::OFS_DEADBAND: rd_mux = {16'h0, deadband};
            acc_pkg::OFS_STATUS: rd_mux = status;
            acc_pkg::OFS_FILT: rd_mux = {16'h0, filt};
            acc_pkg::OFS_CURRENT: rd_mux = {16'h0, cur_now};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign pready = 1'b1;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_WIN_ONE: assert property ((state == acc_pkg::ACC_UPD) && !flush && fset == 3'h0
        |=> sum == acc_pkg::SUM_W'($past(samp))) else $error("window of one not kept");
    AST_TICK_GAP: assert property (tick |=> (!tick) [*8])
        else $error("sample ticks too close");
    AST_ZERO: assert property (forced_zero |-> cmd_now == 16'sh0000)
        else $error("forced zero ignored");
    AST_INVERT: assert property (hist.rd_en && tsel[acc_pkg::TSEL_INVERT_BIT]
        |=> samp == -$signed($past(adc_sample))) else $error("polarity not inverted");
    AST_SPD_SIGN: assert property (lim_mode && cmd_now < 0 && spd_lim[14:0] != 15'h0
        |=> $signed(speed_cmd) < 0) else $error("speed command sign wrong");
    AST_LOOP_SEL: assert property (spd_hit && servo_on
        |-> acc_abs(cur_now) <= cmd_mag) else $error("loop current exceeds command");
    AST_SERVO_CLR: assert property (servo_rise && !ctl_sw[acc_pkg::SW_KEEP_BIT]
        |=> spd_lim == 16'h0000) else $error("speed limit not cleared");
    // The word was latched one edge earlier, against the limit that stood before that edge
    AST_FWD_CAP: assert property (pend && !$past(pend)
        |-> $signed(pend_word) <= $signed({1'b0, $past(fwd_lim[14:0])}))
        else $error("forward limit passed");
    // Current drops in the same cycle; excitation follows one cycle later
    AST_EXCITE: assert property (!servo_on |-> (cur_now == 16'sh0000) ##1 !motor_excite)
        else $error("excited without servo-on");
    AST_APB_ERR: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access not flagged");

    CV_FORCE: cover property (forced_zero && state == acc_pkg::ACC_PUSH);
    CV_FULL: cover property (cnt == 2'h2 && pend);
    CV_HIT: cover property (spd_hit && servo_on);
    CV_WR: cover property (wr_stb && reg_addr == acc_pkg::OFS_CFG);
endmodule
`default_nettype wire

// ===== sim/acc_host_model.sv
// Behavioural host: analog command level and digital inputs of the drive
`timescale 1ns/100ps
`default_nettype none
module acc_host_model
(
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic [15:0] level,
    input wire logic servo_req,
    input wire logic zero_req,
    // Drive pins
    output logic [15:0] adc_sample = 16'h0000,
    output logic [7:0] gen_inputs = 8'h00
);
    // Input 1 carries servo-on, input 8 the forced-zero request
    always @(posedge pclk)
    begin
        adc_sample <= level;
        gen_inputs <= {zero_req, 6'h00, servo_req};
    end
endmodule
`default_nettype wire

// ===== sim/tb_analog_command_conditioner.sv
// Self-checking bench of the analog command conditioner
`timescale 1ns/100ps
`default_nettype none
module tb_analog_command_conditioner;
    localparam int SC = 20;
    typedef struct packed {
        logic [15:0] adc;
        logic [31:0] cfg;
        logic [15:0] spd, ms, slc, fwd, rev, cur, scmd;
    } acc_row_t;
    localparam acc_row_t ROWS [8] = '{
        '{16'h0064, 32'h0, 16'h0, 16'h0, 16'h0, 16'h7fff, 16'h7fff, 16'h0064, 16'h0},
        '{16'h0064, 32'h8000, 16'h0, 16'h0, 16'h0, 16'h7fff, 16'h7fff, 16'hff9c, 16'h0},
        '{16'h03e8, 32'h0, 16'h0, 16'h0, 16'h0, 16'h012c, 16'h7fff, 16'h012c, 16'h0},
        '{16'hfc18, 32'h0, 16'h0, 16'h0, 16'h0, 16'h7fff, 16'h00c8, 16'hff38, 16'h0},
        '{16'h0064, 32'h20300, 16'h01f4, 16'h0064, 16'h0, 16'h7fff, 16'h7fff, 16'h0064, 16'h01f4},
        '{16'hff9c, 32'h20300, 16'h01f4, 16'h0064, 16'h0, 16'h7fff, 16'h7fff, 16'hff9c, 16'hfe0c},
        '{16'h0064, 32'h20300, 16'h01f4, 16'h0258, 16'h0032, 16'h7fff, 16'h7fff, 16'h0032, 16'h01f4},
        '{16'h0064, 32'h20300, 16'h01f4, 16'h0258, 16'h03e8, 16'h7fff, 16'h7fff, 16'h0064, 16'h01f4}
    };
    localparam logic [7:0] RA [5] = '{acc_pkg::OFS_INFUNC_LO, acc_pkg::OFS_INFUNC_HI,
        acc_pkg::OFS_FWDLIM, acc_pkg::OFS_REVLIM, acc_pkg::OFS_SPDLIM};
    localparam logic [31:0] RV [5] = '{acc_pkg::INFUNC_LO_RST, acc_pkg::INFUNC_HI_RST,
        {16'h0, acc_pkg::LIM_RST}, {16'h0, acc_pkg::LIM_RST}, 32'h0};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cur_ready = 1;
    logic servo = 1, zero = 0, pready, pslverr, cur_valid, motor_excite, e;
    logic [7:0] paddr = 8'h00;
    logic [7:0] gen_inputs;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] level = 16'h0190, motor_speed = 16'h0, slc = 16'h0;
    logic [15:0] adc_sample, cur_data, speed_cmd, w;
    int num_errors = 0, comparisons = 0, cyc = 0, last_pop = 0, n = 0, k = 0;

    always #5 pclk = ~pclk;

    acc_top #(.SAMPLE_CYCLES(SC)) acc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample), .gen_inputs(gen_inputs),
        .motor_speed(motor_speed), .speed_loop_current(slc), .cur_valid(cur_valid),
        .cur_ready(cur_ready), .cur_data(cur_data), .speed_cmd(speed_cmd),
        .motor_excite(motor_excite));
    acc_host_model acc_host_model_inst (.pclk(pclk), .level(level), .servo_req(servo),
        .zero_req(zero), .adc_sample(adc_sample), .gen_inputs(gen_inputs));

    // ****************************************
    // Helpers
    // ****************************************
    task close_out();
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            num_errors++;
        end
    endtask

    // One APB transfer; the request stands until pready is seen at an edge
    task apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Waits for one word taken from the stream, and the cycles since the last
    task pop();
        do @(posedge pclk); while (!(cur_valid === 1'b1 && cur_ready === 1'b1));
        w = cur_data;
        n = cyc - last_pop;
        last_pop = cyc;
    endtask

    // Ceiling well above the thousand or fewer cycles the sequence needs
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            num_errors++;
            close_out();
        end
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (20) @(posedge pclk);
        chk("cur_valid", 0, 32'(cur_valid));
        chk("motor_excite", 0, 32'(motor_excite));
        presetn <= 1;
        apb(acc_pkg::OFS_CFG, 0, 0);
        chk("cfg", acc_pkg::CFG_RST, q);
        // Four-sample window set before the first tick: the window fills from zeros
        apb(acc_pkg::OFS_CFG, 1, 32'h2);
        for (int i = 1; i <= 5; i++)
        begin
            pop();
            chk("fill_word", 32'(100 * (i < 4 ? i : 4)), 32'(w));
            if (i > 1)
                chk("tick_gap", SC, n);
        end
        foreach (RA[i])
        begin
            apb(RA[i], 0, 0);
            chk("reg_reset", RV[i], q);
        end
        apb(8'h2c, 0, 0);
        chk("unmapped_err", 1, 32'(e));
        chk("unmapped_data", 0, q);
        apb(8'h05, 1, 32'h1);
        chk("unaligned_err", 1, 32'(e));
        foreach (ROWS[i])
        begin
            level <= ROWS[i].adc;
            motor_speed <= ROWS[i].ms;
            slc <= ROWS[i].slc;
            apb(acc_pkg::OFS_CFG, 1, ROWS[i].cfg);
            apb(acc_pkg::OFS_SPDLIM, 1, 32'(ROWS[i].spd));
            apb(acc_pkg::OFS_FWDLIM, 1, 32'(ROWS[i].fwd));
            apb(acc_pkg::OFS_REVLIM, 1, 32'(ROWS[i].rev));
            repeat (2) pop();
            apb(acc_pkg::OFS_CURRENT, 0, 0);
            chk("current", 32'(ROWS[i].cur), 32'(q[15:0]));
            chk("word", 32'(ROWS[i].cur), 32'(w));
            chk("speed_cmd", 32'(ROWS[i].scmd), 32'(speed_cmd));
        end
        // ****************************************
        // Override, dead band, servo-on, stall
        // ****************************************
        apb(acc_pkg::OFS_CFG, 1, 0);
        level <= 16'h01f4;
        apb(acc_pkg::OFS_INFUNC_HI, 1, 32'h0e00_0000);
        zero <= 1;
        repeat (3) @(posedge pclk);
        apb(acc_pkg::OFS_CURRENT, 0, 0);
        chk("forced_zero", 0, q);
        apb(acc_pkg::OFS_STATUS, 0, 0);
        chk("zero_flag", 1, 32'(q[acc_pkg::ST_ZERO_BIT]));
        pop();
        chk("forced_word", 0, 32'(w));
        zero <= 0;
        for (int i = 0; i < 2; i++)
        begin
            apb(acc_pkg::OFS_DEADBAND, 1, 32'h1f4 - 32'(i));
            repeat (2) pop();
            chk("dead_band", i == 0 ? 0 : 32'h1f4, 32'(w));
        end
        // Band of 499 now centred on an offset of 100: a level of 500 sits inside it
        apb(acc_pkg::OFS_OFFSET, 1, 32'h64);
        repeat (2) pop();
        chk("band_offset", 0, 32'(w));
        apb(acc_pkg::OFS_FILT, 0, 0);
        chk("filt", 32'h1f4, q);
        for (int i = 0; i < 2; i++)
        begin
            apb(acc_pkg::OFS_CFG, 1, i == 0 ? 32'h0 : 32'h0400_0000);
            apb(acc_pkg::OFS_SPDLIM, 1, 32'h1f4);
            servo <= 0;
            repeat (3) @(posedge pclk);
            chk("excite_off", 0, 32'(motor_excite));
            apb(acc_pkg::OFS_CURRENT, 0, 0);
            chk("current_off", 0, q);
            servo <= 1;
            repeat (3) @(posedge pclk);
            chk("excite_on", 1, 32'(motor_excite));
            apb(acc_pkg::OFS_SPDLIM, 0, 0);
            chk("speed_limit", i == 0 ? 0 : 32'h1f4, q);
        end
        // Stall aligned to a pop so that no fresh tick lands in the burst
        pop();
        cur_ready <= 0;
        repeat (5 * SC) @(posedge pclk);
        chk("held_valid", 1, 32'(cur_valid));
        cur_ready <= 1;
        repeat (8)
        begin
            @(posedge pclk);
            if (cur_valid === 1'b1 && cur_ready === 1'b1)
                k++;
        end
        chk("burst_words", 3, k);
        chk("drained", 0, 32'(cur_valid));
        close_out();
    end
endmodule
`default_nettype wire
